// ==== lqta_cfg.svh ====
// Constants for the link quality threshold access register
`ifndef LQTA_CFG_SVH
`define LQTA_CFG_SVH

// =====================================================================
// Register placement
`define LQTA_PAGE 2'h2
`define LQTA_ADDR 5'h1E
`define LQTA_RESET 16'h0000

// =====================================================================
// Field positions
`define LQTA_RSVD_HI 15
`define LQTA_RSVD_LO 14
`define LQTA_SAMPLE_BIT 13
`define LQTA_STROBE_BIT 12
`define LQTA_PSEL_HI 11
`define LQTA_PSEL_LO 9
`define LQTA_BOUND_BIT 8
`define LQTA_DATA_HI 7
`define LQTA_DATA_LO 0

// =====================================================================
// Parameter selector codes and threshold limits
`define LQTA_SEL_EQ 3'h0
`define LQTA_SEL_GAIN 3'h1
`define LQTA_SEL_BLW 3'h2
`define LQTA_SEL_FOFS 3'h3
`define LQTA_SEL_FCTL 3'h4
`define LQTA_NUM_PARAM 5
`define LQTA_THR_MIN 8'h00
`define LQTA_THR_MAX 8'hFF

`endif

// ==== lqta_pkg.sv ====
// Types shared by the link quality threshold access register
package lqta_pkg;

    // Management port request, one cycle per access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] page;
        logic [4:0] addr;
        logic [15:0] wdata;
    } lqta_mgmt_req_t;

    // Adapted receiver parameters, index = parameter selector code
    typedef logic [4:0][7:0] lqta_param_vec_t;

    // Violation levels, one bit per parameter
    typedef struct packed {
        logic [4:0] low;
        logic [4:0] high;
    } lqta_warn_t;

    // Whole module state
    typedef struct packed {
        logic        sample_en;
        logic [2:0]  param_sel;
        logic        bound_sel;
        logic [7:0]  data_field;
        logic [7:0]  sample_val;
        logic [9:0][7:0] thr;
        logic        rd_valid;
        logic [15:0] rdata;
        lqta_warn_t  warn;
    } lqta_state_t;

endpackage : lqta_pkg

// ==== lqta_threshold_reg.sv ====
// Link quality threshold and parameter access register, one port
`timescale 1ns/100ps
`include "lqta_cfg.svh"

module lqta_threshold_reg
    import lqta_pkg::*;
(
    input wire logic clk, // 125 MHz device clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire lqta_mgmt_req_t mgmt_req, // Decoded management access
    output logic mgmt_rd_valid, // Read answer pulse
    output logic [15:0] mgmt_rdata, // Read answer word
    input wire logic power_down, // Port in power-down
    input wire logic link_100_valid, // Valid 100 Mb/s link
    input wire logic monitor_enable, // Monitor enable from control register
    input wire lqta_param_vec_t param_value, // Adapted parameters from the DSP
    output lqta_warn_t warn // Current threshold violations
);

    // =================================================================
    // Helpers
    function automatic logic [3:0] thr_index(input logic [2:0] psel, input logic bound);
        thr_index = {psel, bound};
    endfunction : thr_index

    function automatic logic sel_legal(input logic [2:0] psel);
        sel_legal = (psel <= `LQTA_SEL_FCTL);
    endfunction : sel_legal

    // =================================================================
    // State
    lqta_state_t s_reg;
    lqta_state_t s_next;
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic [2:0] w_psel;
    logic w_bound;
    logic [7:0] w_data;
    logic mon_active;
    logic [7:0] cur_thr;
    logic [7:0] lo_thr;
    logic [7:0] hi_thr;

    // =================================================================
    // Request decode
    assign hit = (mgmt_req.page == `LQTA_PAGE) && (mgmt_req.addr == `LQTA_ADDR);
    assign wr_hit = hit && mgmt_req.wr;
    assign rd_hit = hit && mgmt_req.rd;
    assign w_psel = mgmt_req.wdata[`LQTA_PSEL_HI:`LQTA_PSEL_LO];
    assign w_bound = mgmt_req.wdata[`LQTA_BOUND_BIT];
    assign w_data = mgmt_req.wdata[`LQTA_DATA_HI:`LQTA_DATA_LO];
    assign mon_active = link_100_valid && monitor_enable;
    // Unused selector codes have no threshold behind them and read zero
    assign cur_thr = sel_legal(s_reg.param_sel) ?
                     s_reg.thr[thr_index(s_reg.param_sel, s_reg.bound_sel)] : `LQTA_THR_MIN;

    // =================================================================
    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.rd_valid = 1'b0;
        lo_thr = `LQTA_THR_MIN;
        hi_thr = `LQTA_THR_MIN;
        if (wr_hit) begin
            // Strobe is not stored, so it always reads back zero
            s_next.sample_en = mgmt_req.wdata[`LQTA_SAMPLE_BIT];
            s_next.param_sel = w_psel;
            s_next.bound_sel = w_bound;
            // Kept as written; reads show the threshold or the sample instead
            s_next.data_field = w_data;
            if (mgmt_req.wdata[`LQTA_SAMPLE_BIT]) begin
                // A new sample starts a new read sequence
                s_next.sample_val = sel_legal(w_psel) ? param_value[w_psel] : `LQTA_THR_MIN;
            end
            // Takes selector and data from this very write
            if (mgmt_req.wdata[`LQTA_STROBE_BIT] && !power_down && sel_legal(w_psel)) begin
                s_next.thr[thr_index(w_psel, w_bound)] = w_data;
            end
        end
        if (rd_hit) begin
            s_next.rd_valid = 1'b1;
            s_next.rdata = `LQTA_RESET;
            s_next.rdata[`LQTA_SAMPLE_BIT] = s_reg.sample_en;
            s_next.rdata[`LQTA_PSEL_HI:`LQTA_PSEL_LO] = s_reg.param_sel;
            s_next.rdata[`LQTA_BOUND_BIT] = s_reg.bound_sel;
            s_next.rdata[`LQTA_DATA_HI:`LQTA_DATA_LO] =
                s_reg.sample_en ? s_reg.sample_val : cur_thr;
        end
        for (int i = 0; i < `LQTA_NUM_PARAM; i++) begin
            lo_thr = s_reg.thr[thr_index(3'(i), 1'b0)];
            hi_thr = s_reg.thr[thr_index(3'(i), 1'b1)];
            // Extreme thresholds can never be crossed, so the check is off
            s_next.warn.low[i] = mon_active && (lo_thr != `LQTA_THR_MIN)
                                 && (param_value[i] < lo_thr);
            s_next.warn.high[i] = mon_active && (hi_thr != `LQTA_THR_MAX)
                                  && (param_value[i] > hi_thr);
        end
    end

    // =================================================================
    // State register
    // Reset also clears every high threshold to zero, so high checks are
    // live at once; software must program thresholds before enabling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // =================================================================
    // Outputs
    assign mgmt_rd_valid = s_reg.rd_valid;
    assign mgmt_rdata = s_reg.rdata;
    assign warn = s_reg.warn;

    // =================================================================
    // Checks
    pwrdn_write_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && power_down) |=> (s_reg.thr == $past(s_reg.thr)))
        else $error("threshold changed during power-down");

    reserved_bits_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        mgmt_rd_valid |-> (mgmt_rdata[`LQTA_RSVD_HI:`LQTA_RSVD_LO] == 2'h0))
        else $error("reserved bits read nonzero");

    sample_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && mgmt_req.wdata[`LQTA_SAMPLE_BIT] && w_psel == `LQTA_SEL_BLW)
        |=> (s_reg.sample_val == $past(param_value[2])))
        else $error("sample did not capture parameter");

    strobe_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        mgmt_rd_valid |-> !mgmt_rdata[`LQTA_STROBE_BIT])
        else $error("write strobe read back as one");

    thr_write_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && mgmt_req.wdata[`LQTA_STROBE_BIT] && !power_down && sel_legal(w_psel))
        |=> (s_reg.thr[thr_index($past(w_psel), $past(w_bound))] == $past(w_data)))
        else $error("threshold write not applied");

    thr_read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_hit && !s_reg.sample_en) |=> mgmt_rd_valid
        && (mgmt_rdata[`LQTA_DATA_HI:`LQTA_DATA_LO] == $past(cur_thr)))
        else $error("threshold read mismatch");

    sample_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_hit && mgmt_req.wdata[`LQTA_SAMPLE_BIT]) |=> $stable(s_reg.sample_val))
        else $error("sampled value changed without new sample");

    no_link_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !link_100_valid ##1 !link_100_valid |-> (warn == '0))
        else $error("violation reported without link");

    // The compare logic is the same for every index, so one parameter stands for all
    high_violation_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mon_active && s_reg.thr[thr_index(`LQTA_SEL_GAIN, 1'b1)] != `LQTA_THR_MAX
        && param_value[`LQTA_SEL_GAIN] > s_reg.thr[thr_index(`LQTA_SEL_GAIN, 1'b1)])
        |=> warn.high[`LQTA_SEL_GAIN])
        else $error("high violation not reported");

    low_violation_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mon_active && s_reg.thr[thr_index(`LQTA_SEL_GAIN, 1'b0)] != `LQTA_THR_MIN
        && param_value[`LQTA_SEL_GAIN] < s_reg.thr[thr_index(`LQTA_SEL_GAIN, 1'b0)])
        |=> warn.low[`LQTA_SEL_GAIN])
        else $error("low violation not reported");

    no_enable_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !monitor_enable
        |=> (warn == '0))
        else $error("violation reported while monitor disabled");

    sample_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_hit && s_reg.sample_en)
        |=> (mgmt_rdata[`LQTA_DATA_HI:`LQTA_DATA_LO] == $past(s_reg.sample_val)))
        else $error("sampled value not returned");

    sample_bit_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_hit
        |=> (s_reg.sample_en == $past(mgmt_req.wdata[`LQTA_SAMPLE_BIT])))
        else $error("sample bit not stored");

    illegal_sample_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && mgmt_req.wdata[`LQTA_SAMPLE_BIT] && !sel_legal(w_psel))
        |=> (s_reg.sample_val == `LQTA_THR_MIN))
        else $error("unused selector sampled nonzero");

    rd_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
        mgmt_rd_valid |-> ((mgmt_rdata[`LQTA_PSEL_HI:`LQTA_PSEL_LO] == $past(s_reg.param_sel))
        && (mgmt_rdata[`LQTA_BOUND_BIT] == $past(s_reg.bound_sel))))
        else $error("selector fields read wrong");

    illegal_sel_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_hit && !s_reg.sample_en && !sel_legal(s_reg.param_sel))
        |=> (mgmt_rdata[`LQTA_DATA_HI:`LQTA_DATA_LO] == `LQTA_THR_MIN))
        else $error("unused selector read nonzero");

    illegal_write_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && !sel_legal(w_psel))
        |=> (s_reg.thr == $past(s_reg.thr)))
        else $error("threshold changed by unused selector");

    pwrdn_fields_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_hit && power_down)
        |=> (s_reg.param_sel == $past(w_psel)))
        else $error("selector not stored during power-down");

    rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rd_hit
        |=> $stable(mgmt_rdata))
        else $error("read word changed without a read");

    rd_answer_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rd_hit
        |=> !mgmt_rd_valid)
        else $error("read answer without a read");

endmodule : lqta_threshold_reg

// ==== tb_lqta_threshold_reg.sv ====
// Self-checking testbench for the link quality threshold access register
`timescale 1ns/100ps
`include "lqta_cfg.svh"
module tb_top import lqta_pkg::*;;
    logic clk;
    logic rst_n;
    lqta_mgmt_req_t mgmt_req;
    logic mgmt_rd_valid;
    logic [15:0] mgmt_rdata;
    logic power_down;
    logic link_100_valid;
    logic monitor_enable;
    lqta_param_vec_t param_value;
    lqta_warn_t warn;
    int n_errors;
    int cmp_count;

    lqta_threshold_reg dut_u (.clk(clk), .rst_n(rst_n), .mgmt_req(mgmt_req),
        .mgmt_rd_valid(mgmt_rd_valid), .mgmt_rdata(mgmt_rdata), .power_down(power_down),
        .link_100_valid(link_100_valid), .monitor_enable(monitor_enable),
        .param_value(param_value), .warn(warn));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // =================================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // One access; leaves a free cycle so strobes never toggle twice in a step
    task automatic access(input logic w, input logic [1:0] pg, input logic [4:0] ad,
                          input logic [15:0] d);
        @(posedge clk);
        #1;
        mgmt_req = '{wr: w, rd: !w, page: pg, addr: ad, wdata: d};
        @(posedge clk);
        #1;
        mgmt_req = '0;
    endtask : access

    task automatic wr(input logic [15:0] d);
        access(1'b1, `LQTA_PAGE, `LQTA_ADDR, d);
    endtask : wr

    task automatic rd(input logic [15:0] exp);
        access(1'b0, `LQTA_PAGE, `LQTA_ADDR, 16'h0000);
        check("rd_valid", {15'h0000, mgmt_rd_valid}, 16'h0001);
        check("rdata", mgmt_rdata, exp);
    endtask : rd

    function automatic logic [7:0] thr_val(input int s, input int b);
        return 8'(s * 34 + b * 17 + 5);
    endfunction : thr_val

    // =================================================================
    // Scenarios
    task automatic sc_thresholds();
        for (int s = 0; s < 5; s++) begin
            for (int b = 0; b < 2; b++) begin
                wr(16'hD000 | 16'(s << 9) | 16'(b << 8) | 16'(thr_val(s, b)));
            end
        end
        for (int s = 0; s < 5; s++) begin
            for (int b = 0; b < 2; b++) begin
                wr(16'(s << 9) | 16'(b << 8));
                rd(16'(s << 9) | 16'(b << 8) | 16'(thr_val(s, b)));
            end
        end
    endtask : sc_thresholds

    task automatic sc_refused();
        power_down = 1'b1;
        wr(16'h1377);
        power_down = 1'b0;
        rd(16'h0300 | 16'(thr_val(1, 1)));
        access(1'b1, 2'h1, `LQTA_ADDR, 16'h1055);
        access(1'b1, `LQTA_PAGE, 5'h1D, 16'h1055);
        rd(16'h0300 | 16'(thr_val(1, 1)));
        access(1'b0, `LQTA_PAGE, 5'h1D, 16'h0000);
        check("foreign_rd", {15'h0000, mgmt_rd_valid}, 16'h0000);
        wr(16'hC300);
        rd(16'h0300 | 16'(thr_val(1, 1)));
        wr(16'h1A55);
        rd(16'h0A00);
        wr(16'h2C00);
        rd(16'h2C00);
    endtask : sc_refused

    task automatic sc_sample();
        for (int s = 0; s < 5; s++) begin
            param_value[s] = 8'(160 + s);
            wr(16'h2000 | 16'(s << 9));
            param_value[s] = 8'h00;
            rd(16'h2000 | 16'(s << 9) | 16'(160 + s));
        end
        wr(16'h0200);
    endtask : sc_sample

    // Parameter 1 thresholds: low 0x27, high 0x38
    task automatic warn_step(input logic lnk, input logic [7:0] p, input logic [15:0] exp);
        link_100_valid = lnk;
        param_value[1] = p;
        repeat (2) @(posedge clk);
        #1;
        check("warn_1", {14'h0000, warn.high[1], warn.low[1]}, exp);
    endtask : warn_step

    task automatic sc_monitor();
        monitor_enable = 1'b1;
        warn_step(1'b1, 8'h40, 16'h0002);
        warn_step(1'b1, 8'h10, 16'h0001);
        warn_step(1'b0, 8'h40, 16'h0000);
        wr(16'h13FF);
        warn_step(1'b1, 8'hFF, 16'h0000);
    endtask : sc_monitor

    task automatic sc_reset();
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("rst_rdata", mgmt_rdata, `LQTA_RESET);
        check("rst_warn", {6'h00, warn}, 16'h0000);
        wr(16'h0300);
        rd(16'h0300);
    endtask : sc_reset

    // =================================================================
    // Main sequence
    initial begin
        n_errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        mgmt_req = '0;
        power_down = 1'b0;
        link_100_valid = 1'b0;
        monitor_enable = 1'b0;
        param_value = '0;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd(`LQTA_RESET);
        sc_thresholds();
        sc_refused();
        sc_sample();
        sc_monitor();
        sc_reset();
        give_verdict();
    end

    // Hang guard well beyond the longest sequence
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
endmodule : tb_top
